// file: inc/rx_pkg.sv
package rx_pkg;

  // ==========================================================================
  // instruction bytes
  localparam logic [7:0] OP_BITOPS    = 8'hCB;
  localparam logic [7:0] OP_EXT       = 8'hED;
  localparam logic [7:0] OP_BASE0     = 8'hDD;
  localparam logic [7:0] OP_BASE1     = 8'hFD;
  localparam logic [7:0] OP_EX_DE_HL  = 8'hEB;
  localparam logic [7:0] OP_EX_AF     = 8'h08;
  localparam logic [7:0] OP_SWAP_ALL  = 8'hD9;
  localparam logic [7:0] OP_EX_STACK  = 8'hE3;
  localparam logic [7:0] EXT_DIGIT_L  = 8'h6F;
  localparam logic [7:0] EXT_DIGIT_R  = 8'h67;
  localparam logic [7:0] EXT_COPY_ADV = 8'hA0;
  localparam logic [7:0] EXT_COPY_RET = 8'hA8;
  localparam logic [7:0] EXT_CMP_ADV  = 8'hA1;

  // shift group field [5:3] and operand field [2:0]
  localparam logic [2:0] SH_ROT_CIRC_R  = 3'h1;
  localparam logic [2:0] SH_ROT_CARRY_L = 3'h2;
  localparam logic [2:0] SH_ARITH_L     = 3'h4;
  localparam logic [2:0] SH_ARITH_R     = 3'h5;
  localparam logic [2:0] MEM_OPERAND    = 3'h6;

  localparam int PREFIX_SEL_POS = 5;
  localparam int DIR_POS        = 3;

  // ==========================================================================
  // flag positions
  localparam int FL_S  = 7;
  localparam int FL_Z  = 6;
  localparam int FL_H  = 4;
  localparam int FL_PV = 2;
  localparam int FL_N  = 1;
  localparam int FL_C  = 0;

  // ==========================================================================
  // lengths in T states, one clock per T state
  localparam logic [4:0] T_SHIFT_PTR = 5'h0F;
  localparam logic [4:0] T_SHIFT_IDX = 5'h17;
  localparam logic [4:0] T_DIGIT     = 5'h12;
  localparam logic [4:0] T_SWAP      = 5'h04;
  localparam logic [4:0] T_STACK_PTR = 5'h13;
  localparam logic [4:0] T_STACK_IDX = 5'h17;
  localparam logic [4:0] T_BLOCK     = 5'h10;

  // memory phases within an instruction
  localparam logic [4:0] PH_RD_LO  = 5'h00;
  localparam logic [4:0] PH_RD_HI  = 5'h01;
  localparam logic [4:0] PH_CAP_LO = 5'h02;
  localparam logic [4:0] PH_CAP_HI = 5'h03;
  localparam logic [4:0] PH_WR_LO  = 5'h03;
  localparam logic [4:0] PH_WR_HI  = 5'h04;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // register load select
  localparam logic [2:0] SEL_AF = 3'h0;
  localparam logic [2:0] SEL_BC = 3'h1;
  localparam logic [2:0] SEL_DE = 3'h2;
  localparam logic [2:0] SEL_HL = 3'h3;
  localparam logic [2:0] SEL_IX = 3'h4;
  localparam logic [2:0] SEL_IY = 3'h5;
  localparam logic [2:0] SEL_SP = 3'h6;

  typedef enum logic [3:0] {
    K_NONE, K_SHIFT, K_DIGIT, K_EX_DE_HL, K_EX_AF, K_SWAP_ALL, K_EX_STACK, K_COPY, K_CMP
  } rx_kind_t;

endpackage

// file: hw/rx_shift_unit.sv
`timescale 1ns/1ps
module rx_shift_unit import rx_pkg::*; (
  input  wire logic [2:0] op_i,
  input  wire logic       digit_i,
  input  wire logic       dir_i,
  input  wire logic [7:0] mem_i,
  input  wire logic [7:0] acc_i,
  input  wire logic       cin_i,
  output logic      [7:0] mem_o,
  output logic      [7:0] acc_o,
  output logic            cout_o
);
  always_comb begin
    mem_o  = mem_i;
    acc_o  = acc_i;
    cout_o = cin_i;
    if (digit_i) begin
      // the leftward digit rotation is the opcode with bit 3 set
      if (dir_i) begin
        mem_o = {mem_i[3:0], acc_i[3:0]};
        acc_o = {acc_i[7:4], mem_i[7:4]};
      end else begin
        mem_o = {acc_i[3:0], mem_i[7:4]};
        acc_o = {acc_i[7:4], mem_i[3:0]};
      end
    end else begin
      case (op_i)
        SH_ROT_CARRY_L: begin
          mem_o  = {mem_i[6:0], cin_i};
          cout_o = mem_i[7];
        end
        SH_ROT_CIRC_R: begin
          mem_o  = {mem_i[0], mem_i[7:1]};
          cout_o = mem_i[0];
        end
        SH_ARITH_L: begin
          mem_o  = {mem_i[6:0], 1'b0};
          cout_o = mem_i[7];
        end
        SH_ARITH_R: begin
          mem_o  = {mem_i[7], mem_i[7:1]};
          cout_o = mem_i[0];
        end
        default: begin
          mem_o  = mem_i;
          cout_o = cin_i;
        end
      endcase
    end
  end
endmodule

// file: hw/rx_block_step.sv
`timescale 1ns/1ps
module rx_block_step import rx_pkg::*; (
  input  wire logic        dir_i,
  input  wire logic [15:0] de_i,
  input  wire logic [15:0] hl_i,
  input  wire logic [15:0] bc_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  mem_i,
  output logic      [15:0] de_o,
  output logic      [15:0] hl_o,
  output logic      [15:0] bc_o,
  output logic             more_o,
  output logic      [7:0]  diff_o,
  output logic             half_o
);
  // dir_i low advances the pointers, high retreats them
  assign de_o   = dir_i ? de_i - 16'h0001 : de_i + 16'h0001;
  assign hl_o   = dir_i ? hl_i - 16'h0001 : hl_i + 16'h0001;
  assign bc_o   = bc_i - 16'h0001;
  assign more_o = (bc_o != 16'h0000);
  assign diff_o = acc_i - mem_i;
  assign half_o = (acc_i[3:0] < mem_i[3:0]);
endmodule

// file: hw/rx_exec_unit.sv
`timescale 1ns/1ps
module rx_exec_unit import rx_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  byte0_i,
  input  wire logic [7:0]  byte1_i,
  input  wire logic [7:0]  byte2_i,
  input  wire logic [7:0]  byte3_i,
  input  wire logic        reg_wr_i,
  input  wire logic [2:0]  reg_sel_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             illegal_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [15:0] mem_addr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  flags_o,
  output logic      [15:0] bc_o,
  output logic      [15:0] de_o,
  output logic      [15:0] hl_o,
  output logic      [15:0] ix_o,
  output logic      [15:0] iy_o,
  output logic      [15:0] sp_o
);
  // ==========================================================================
  // register set
  logic [7:0]  acc, flg, acc_alt, flg_alt;
  logic [15:0] bc, de, hl, ix, iy, sp, bc_alt, de_alt, hl_alt;

  // ==========================================================================
  // sequencing state
  rx_kind_t    kind, next_kind;
  logic [4:0]  tcnt, len, next_len;
  logic [2:0]  sh_op, next_op;
  logic [1:0]  xsel, next_xsel;
  logic        dir, indexed, next_indexed;
  logic [15:0] ea, next_ea, base;
  logic [7:0]  rdat_lo, rdat_hi;

  logic [7:0]  sh_mem, sh_acc, diff;
  logic        sh_c, more, half;
  logic [15:0] de_step, hl_step, bc_step, xreg;

  // ==========================================================================
  // decode of the presented bytes
  always_comb begin
    next_kind    = K_NONE;
    next_len     = T_SWAP;
    next_op      = byte1_i[5:3];
    next_xsel    = 2'h0;
    next_indexed = 1'b0;
    next_ea      = hl;
    base         = byte0_i[PREFIX_SEL_POS] ? iy : ix;
    case (byte0_i)
      OP_BITOPS: begin
        if (byte1_i[2:0] == MEM_OPERAND && (byte1_i[5:3] == SH_ROT_CARRY_L || byte1_i[5:3] == SH_ROT_CIRC_R ||
            byte1_i[5:3] == SH_ARITH_L || byte1_i[5:3] == SH_ARITH_R)) begin
          next_kind = K_SHIFT;
          next_len  = T_SHIFT_PTR;
        end
      end
      OP_BASE0, OP_BASE1: begin
        if (byte1_i == OP_BITOPS && byte3_i[2:0] == MEM_OPERAND && (byte3_i[5:3] == SH_ROT_CARRY_L ||
            byte3_i[5:3] == SH_ROT_CIRC_R || byte3_i[5:3] == SH_ARITH_L || byte3_i[5:3] == SH_ARITH_R)) begin
          next_kind    = K_SHIFT;
          next_len     = T_SHIFT_IDX;
          next_op      = byte3_i[5:3];
          next_indexed = 1'b1;
          next_ea      = base + {{8{byte2_i[7]}}, byte2_i};
        end else if (byte1_i == OP_EX_STACK) begin
          next_kind = K_EX_STACK;
          next_len  = T_STACK_IDX;
          next_xsel = byte0_i[PREFIX_SEL_POS] ? 2'h2 : 2'h1;
          next_ea   = sp;
        end
      end
      OP_EXT: begin
        case (byte1_i)
          EXT_DIGIT_L, EXT_DIGIT_R: begin
            next_kind = K_DIGIT;
            next_len  = T_DIGIT;
          end
          EXT_COPY_ADV, EXT_COPY_RET: begin
            next_kind = K_COPY;
            next_len  = T_BLOCK;
          end
          EXT_CMP_ADV: begin
            next_kind = K_CMP;
            next_len  = T_BLOCK;
          end
          default: next_kind = K_NONE;
        endcase
      end
      OP_EX_DE_HL: next_kind = K_EX_DE_HL;
      OP_EX_AF:    next_kind = K_EX_AF;
      OP_SWAP_ALL: next_kind = K_SWAP_ALL;
      OP_EX_STACK: begin
        next_kind = K_EX_STACK;
        next_len  = T_STACK_PTR;
        next_ea   = sp;
      end
      default: next_kind = K_NONE;
    endcase
  end

  rx_shift_unit u_shift (
    .op_i    (sh_op),
    .digit_i (kind == K_DIGIT),
    .dir_i   (dir),
    .mem_i   (rdat_lo),
    .acc_i   (acc),
    .cin_i   (flg[FL_C]),
    .mem_o   (sh_mem),
    .acc_o   (sh_acc),
    .cout_o  (sh_c)
  );

  rx_block_step u_step (
    .dir_i   (dir),
    .de_i    (de),
    .hl_i    (hl),
    .bc_i    (bc),
    .acc_i   (acc),
    .mem_i   (rdat_lo),
    .de_o    (de_step),
    .hl_o    (hl_step),
    .bc_o    (bc_step),
    .more_o  (more),
    .diff_o  (diff),
    .half_o  (half)
  );

  assign xreg = (xsel == 2'h1) ? ix : (xsel == 2'h2) ? iy : hl;

  // ==========================================================================
  // sequencer: busy stands exactly len cycles, done marks the last one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      illegal_o <= 1'b0;
      tcnt      <= 5'h00;
      len       <= T_SWAP;
      kind      <= K_NONE;
      sh_op     <= 3'h0;
      xsel      <= 2'h0;
      dir       <= 1'b0;
      indexed   <= 1'b0;
      ea        <= RST_WORD;
    end else if (ce_i) begin
      illegal_o <= 1'b0;
      done_o    <= busy_o && (tcnt == len - 5'h02);
      if (!busy_o) begin
        if (start_i && next_kind != K_NONE) begin
          busy_o  <= 1'b1;
          tcnt    <= 5'h00;
          len     <= next_len;
          kind    <= next_kind;
          sh_op   <= next_op;
          xsel    <= next_xsel;
          dir     <= byte1_i[DIR_POS];
          indexed <= next_indexed;
          ea      <= next_ea;
        end else begin
          illegal_o <= start_i;
        end
      end else if (tcnt == len - 5'h01) begin
        busy_o <= 1'b0;
      end else begin
        tcnt <= tcnt + 5'h01;
      end
    end
  end

  // ==========================================================================
  // memory side: a read is answered one cycle after it is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_addr_o  <= RST_WORD;
      mem_wdata_o <= RST_BYTE;
      rdat_lo     <= RST_BYTE;
      rdat_hi     <= RST_BYTE;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (busy_o && kind != K_EX_DE_HL && kind != K_EX_AF && kind != K_SWAP_ALL) begin
        if (tcnt == PH_RD_LO) begin
          mem_rd_o   <= 1'b1;
          mem_addr_o <= (kind == K_COPY || kind == K_CMP) ? hl : ea;
        end
        if (tcnt == PH_RD_HI && kind == K_EX_STACK) begin
          mem_rd_o   <= 1'b1;
          mem_addr_o <= ea + 16'h0001;
        end
        if (tcnt == PH_CAP_LO) rdat_lo <= mem_rdata_i;
        if (tcnt == PH_CAP_HI) rdat_hi <= mem_rdata_i;
        if (tcnt == PH_WR_LO && kind != K_CMP) begin
          mem_wr_o <= 1'b1;
          case (kind)
            K_COPY: begin
              mem_addr_o  <= de;
              mem_wdata_o <= rdat_lo;
            end
            K_EX_STACK: begin
              mem_addr_o  <= ea;
              mem_wdata_o <= xreg[7:0];
            end
            default: begin
              mem_addr_o  <= ea;
              mem_wdata_o <= sh_mem;
            end
          endcase
        end
        if (tcnt == PH_WR_HI && kind == K_EX_STACK) begin
          mem_wr_o    <= 1'b1;
          mem_addr_o  <= ea + 16'h0001;
          mem_wdata_o <= xreg[15:8];
        end
      end
    end
  end

  // ==========================================================================
  // register file; loads are ignored while an instruction runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= RST_BYTE;
      flg <= RST_BYTE;
      acc_alt <= RST_BYTE;
      flg_alt <= RST_BYTE;
      {bc, de, hl, ix, iy, sp} <= {6{RST_WORD}};
      {bc_alt, de_alt, hl_alt} <= {3{RST_WORD}};
    end else if (ce_i) begin
      if (!busy_o && reg_wr_i) begin
        case (reg_sel_i)
          SEL_AF: {acc, flg} <= reg_wdata_i;
          SEL_BC: bc <= reg_wdata_i;
          SEL_DE: de <= reg_wdata_i;
          SEL_HL: hl <= reg_wdata_i;
          SEL_IX: ix <= reg_wdata_i;
          SEL_IY: iy <= reg_wdata_i;
          SEL_SP: sp <= reg_wdata_i;
          default: sp <= sp;
        endcase
      end else if (busy_o && tcnt == len - 5'h01) begin
        case (kind)
          K_SHIFT, K_DIGIT: begin
            if (kind == K_DIGIT) acc <= sh_acc;
            flg[FL_S]  <= (kind == K_DIGIT) ? sh_acc[7] : sh_mem[7];
            flg[FL_Z]  <= (kind == K_DIGIT) ? (sh_acc == 8'h00) : (sh_mem == 8'h00);
            flg[FL_PV] <= (kind == K_DIGIT) ? ~^sh_acc : ~^sh_mem;
            flg[FL_H]  <= 1'b0;
            flg[FL_N]  <= 1'b0;
            if (kind == K_SHIFT) flg[FL_C] <= sh_c;
          end
          K_EX_DE_HL: begin
            de <= hl;
            hl <= de;
          end
          K_EX_AF: begin
            {acc, flg} <= {acc_alt, flg_alt};
            {acc_alt, flg_alt} <= {acc, flg};
          end
          K_SWAP_ALL: begin
            {bc, de, hl} <= {bc_alt, de_alt, hl_alt};
            {bc_alt, de_alt, hl_alt} <= {bc, de, hl};
          end
          K_EX_STACK: begin
            case (xsel)
              2'h1: ix <= {rdat_hi, rdat_lo};
              2'h2: iy <= {rdat_hi, rdat_lo};
              default: hl <= {rdat_hi, rdat_lo};
            endcase
          end
          K_COPY: begin
            de <= de_step;
            hl <= hl_step;
            bc <= bc_step;
            flg[FL_H]  <= 1'b0;
            flg[FL_N]  <= 1'b0;
            flg[FL_PV] <= more;
          end
          K_CMP: begin
            hl <= hl_step;
            bc <= bc_step;
            flg[FL_S]  <= diff[7];
            flg[FL_Z]  <= (diff == 8'h00);
            flg[FL_H]  <= half;
            flg[FL_N]  <= 1'b1;
            flg[FL_PV] <= more;
          end
          default: flg <= flg;
        endcase
      end
    end
  end

  assign {acc_o, flags_o, bc_o, de_o, hl_o} = {acc, flg, bc, de, hl};
  assign {ix_o, iy_o, sp_o} = {ix, iy, sp};

  // ==========================================================================
  // checks; busy_len counts the cycles of the instruction just ended
  logic [4:0] busy_len;
  always_ff @(posedge clk_i) begin
    if (rst_i) busy_len <= 5'h00;
    else if (ce_i) busy_len <= busy_o ? busy_len + 5'h01 : 5'h00;
  end

  AST_SHIFT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(busy_o) && kind == K_SHIFT) |-> busy_len == (indexed ? 5'h17 : 5'h0F))
    else $error("memory shift length wrong");
  AST_DIGIT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(busy_o) && kind == K_DIGIT) |-> busy_len == 5'h12)
    else $error("digit rotate length wrong");
  AST_SWAP_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(busy_o) && (kind == K_EX_DE_HL || kind == K_EX_AF || kind == K_SWAP_ALL)) |-> busy_len == 5'h04)
    else $error("register swap length wrong");
  AST_BLOCK_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(busy_o) && (kind == K_COPY || kind == K_CMP)) |-> busy_len == 5'h10)
    else $error("block step length wrong");
  AST_SHIFT_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_SHIFT) |=> !flg[FL_H] && !flg[FL_N] && flg[FL_Z] == (mem_wdata_o == 8'h00)
      && flg[FL_PV] == ~^mem_wdata_o && flg[FL_S] == mem_wdata_o[7])
    else $error("memory shift flags wrong");
  AST_RL_CARRY: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_SHIFT && sh_op == SH_ROT_CARRY_L) |=>
      flg[FL_C] == rdat_lo[7] && mem_wdata_o == {rdat_lo[6:0], $past(flg[FL_C])})
    else $error("rotate through carry wrong");
  AST_RRC: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_SHIFT && sh_op == SH_ROT_CIRC_R) |=>
      flg[FL_C] == rdat_lo[0] && mem_wdata_o == {rdat_lo[0], rdat_lo[7:1]})
    else $error("circular right rotate wrong");
  AST_SRA: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_SHIFT && sh_op == SH_ARITH_R) |=>
      flg[FL_C] == rdat_lo[0] && mem_wdata_o == {rdat_lo[7], rdat_lo[7:1]})
    else $error("arithmetic right shift wrong");
  AST_EX_DE_HL: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_EX_DE_HL) |=> de == $past(hl) && hl == $past(de) && flg == $past(flg))
    else $error("pointer pair swap wrong");
  AST_STACK_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(mem_wr_o) && kind == K_EX_STACK) |-> mem_addr_o == sp ##1 mem_wr_o && mem_addr_o == sp + 16'h0001)
    else $error("stack exchange writes wrong");
  AST_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_COPY && !dir) |=> de == $past(de) + 16'h0001 && bc == $past(bc) - 16'h0001
      && flg[FL_PV] == (bc != 16'h0000) && !flg[FL_N] && !flg[FL_H])
    else $error("copy and advance wrong");
  AST_CMP: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_o && ce_i && kind == K_CMP) |=> flg[FL_N] && flg[FL_Z] == (acc == rdat_lo) && hl == $past(hl) + 16'h0001)
    else $error("compare and advance wrong");

endmodule

// file: verif/rx_mem_model.sv
`timescale 1ns/1ps
// ==========================================================================
// byte memory behind the execution unit, one cycle read latency
module rx_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [logic [15:0]];

  initial rdata_o = 8'h00;

  // outside a read the data lines toggle, so a capture on the wrong cycle cannot pass by luck
  always @(posedge clk_i) begin
    if (wr_i === 1'b1) mem[addr_i] = wdata_i;
    rdata_o <= (rd_i === 1'b1) ? mem[addr_i] : ~rdata_o;
  end
endmodule

// file: verif/tb_rx_exec_unit.sv
`timescale 1ns/1ps
module tb_rx_exec_unit import rx_pkg::*; ;
  typedef struct {
    logic [7:0]  acc, flg, m0, m1;
    logic [15:0] cnt, tptr, mptr, base0, base1, stk, ad0, ad1;
    int          len;
  } rx_exp_t;
  logic        clk_i = 0, rst_i = 1, start_i = 0, reg_wr_i = 0;
  logic [7:0]  b0 = 0, b1 = 0, b2 = 0, b3 = 0, rdata, mem_wdata_o, acc_o, flags_o;
  logic [2:0]  reg_sel_i = 0;
  logic [15:0] reg_wdata_i = 0, seed = 16'h0004, mem_addr_o, bc_o, de_o, hl_o, ix_o, iy_o, sp_o;
  logic        busy_o, done_o, illegal_o, mem_rd_o, mem_wr_o;
  logic [7:0]  acc = 0, flg = 0, acc2 = 0, flg2 = 0, smem [logic [15:0]];
  logic [15:0] cnt = 0, tptr = 0, mptr = 0, base0 = 0, base1 = 0, stk = 0, cnt2 = 0, tptr2 = 0, mptr2 = 0;
  logic [2:0]  ops [4] = '{SH_ROT_CARRY_L, SH_ROT_CIRC_R, SH_ARITH_L, SH_ARITH_R};
  rx_exp_t     q [$];
  int          n_errors = 0, check_count = 0, nb = 0;

  always #25 clk_i = ~clk_i;

  rx_exec_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .start_i(start_i), .byte0_i(b0), .byte1_i(b1),
    .byte2_i(b2), .byte3_i(b3), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
    .mem_rdata_i(rdata), .busy_o(busy_o), .done_o(done_o), .illegal_o(illegal_o), .mem_rd_o(mem_rd_o),
    .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o), .flags_o(flags_o),
    .bc_o(bc_o), .de_o(de_o), .hl_o(hl_o), .ix_o(ix_o), .iy_o(iy_o), .sp_o(sp_o));
  rx_mem_model mem_u (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(rdata));

  // ==========================================================================
  // helpers
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_i) #1;
  endtask
  task automatic poke(input logic [15:0] ad, input logic [7:0] v);
    mem_u.mem[ad] = v;
    smem[ad] = v;
  endtask
  task automatic setr(input logic [2:0] s, input logic [15:0] v);
    reg_sel_i = s;
    reg_wdata_i = v;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick();
    case (s)
      SEL_AF: {acc, flg} = v;
      SEL_BC: cnt = v;
      SEL_DE: tptr = v;
      SEL_HL: mptr = v;
      SEL_IX: base0 = v;
      SEL_IY: base1 = v;
      default: stk = v;
    endcase
  endtask
  // expectations must already be in the shadow state when this is called
  task automatic exec(input logic [31:0] ins, input int len, input logic [15:0] ad0, input logic [15:0] ad1);
    int k;
    q.push_back('{acc:acc, flg:flg, m0:smem[ad0], m1:smem[ad1], cnt:cnt, tptr:tptr, mptr:mptr,
                  base0:base0, base1:base1, stk:stk, ad0:ad0, ad1:ad1, len:len});
    {b0, b1, b2, b3} = ins;
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    for (k = 0; k < 40 && done_o !== 1'b1; k++) tick();
    if (k == 40) begin
      chk(1'b0, "no completion");
      conclude();
    end
    tick();
  endtask

  // ==========================================================================
  // result watcher
  always @(posedge clk_i) begin
    rx_exp_t e;
    if (busy_o === 1'b1) nb++;
    if (done_o === 1'b1) begin
      #1;
      if (q.size() == 0) chk(1'b0, "completion without request");
      else begin
        e = q.pop_front();
        chk(nb === e.len, "length");
        chk(acc_o === e.acc && (flags_o & 8'hD7) === (e.flg & 8'hD7), "acc or flags");
        chk({bc_o, de_o, hl_o, ix_o, iy_o, sp_o} === {e.cnt, e.tptr, e.mptr, e.base0, e.base1, e.stk},
            "pairs");
        chk(mem_u.mem[e.ad0] === e.m0 && mem_u.mem[e.ad1] === e.m1, "memory");
      end
      nb = 0;
    end
  end

  // ==========================================================================
  // stimulus
  initial begin
    int i;
    logic [7:0] m, r, d;
    logic [15:0] ad, bp;
    logic [2:0] op;
    logic c;
    poke(16'h0000, 8'h5A);
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (i = 0; i < 12; i++) begin
      setr(SEL_AF, rnd());
      setr(SEL_HL, rnd());
      setr(SEL_IX, rnd());
      setr(SEL_IY, rnd());
      op = ops[i % 4];
      ad = rnd();
      d = ad[7:0];
      m = ad[15:8];
      bp = i < 8 ? base0 : base1;
      ad = i < 4 ? mptr : bp + {{8{d[7]}}, d};
      poke(ad, m);
      case (op)
        SH_ROT_CIRC_R:  {r, c} = {m[0], m[7:1], m[0]};
        SH_ROT_CARRY_L: {c, r} = {m, flg[FL_C]};
        SH_ARITH_L:     {c, r} = {m, 1'b0};
        default:        {r, c} = {m[7], m};
      endcase
      smem[ad] = r;
      flg = {r[7], r == 8'h00, 2'b00, 1'b0, ~^r, 1'b0, c};
      exec(i < 4 ? {OP_BITOPS, 2'b00, op, MEM_OPERAND, 16'h0000}
                 : {i < 8 ? OP_BASE0 : OP_BASE1, OP_BITOPS, d, 2'b00, op, MEM_OPERAND},
           i < 4 ? 15 : 23, ad, ad);
    end
    for (i = 0; i < 2; i++) begin
      ad = rnd();
      m = ad[7:0];
      poke(mptr, m);
      if (i == 0) smem[mptr] = {m[3:0], acc[3:0]};
      else smem[mptr] = {acc[3:0], m[7:4]};
      acc = {acc[7:4], i == 0 ? m[7:4] : m[3:0]};
      flg = {acc[7], acc == 8'h00, 2'b00, 1'b0, ~^acc, 1'b0, flg[FL_C]};
      exec({OP_EXT, i == 0 ? EXT_DIGIT_L : EXT_DIGIT_R, 16'h0000}, 18, mptr, mptr);
    end
    setr(SEL_DE, rnd());
    setr(SEL_BC, rnd());
    for (i = 0; i < 6; i++) begin
      case (i % 3)
        0: {tptr, mptr} = {mptr, tptr};
        1: {acc, flg, acc2, flg2} = {acc2, flg2, acc, flg};
        default: {cnt, tptr, mptr, cnt2, tptr2, mptr2} = {cnt2, tptr2, mptr2, cnt, tptr, mptr};
      endcase
      exec({i % 3 == 0 ? OP_EX_DE_HL : i % 3 == 1 ? OP_EX_AF : OP_SWAP_ALL, 24'h000000}, 4,
           16'h0000, 16'h0000);
    end
    setr(SEL_SP, rnd());
    for (i = 0; i < 3; i++) begin
      ad = rnd();
      poke(stk, ad[7:0]);
      poke(stk + 16'h0001, ad[15:8]);
      bp = i == 0 ? mptr : i == 1 ? base0 : base1;
      smem[stk] = bp[7:0];
      smem[stk + 16'h0001] = bp[15:8];
      if (i == 0) mptr = ad;
      else if (i == 1) base0 = ad;
      else base1 = ad;
      exec(i == 0 ? {OP_EX_STACK, 24'h000000} : {i == 1 ? OP_BASE0 : OP_BASE1, OP_EX_STACK, 16'h0000},
           i == 0 ? 19 : 23, stk, stk + 16'h0001);
    end
    for (i = 0; i < 4; i++) begin
      setr(SEL_BC, i[0] ? rnd() : 16'h0001);
      ad = rnd();
      m = i == 2 ? acc : ad[7:0];
      poke(mptr, m);
      poke(tptr, ad[15:8]);
      bp = tptr;
      cnt = cnt - 16'h0001;
      if (i < 2) begin
        smem[tptr] = m;
        flg[FL_H] = 1'b0;
        flg[FL_N] = 1'b0;
        flg[FL_PV] = cnt != 16'h0000;
        tptr = i == 0 ? tptr + 16'h0001 : tptr - 16'h0001;
      end else begin
        r = acc - m;
        flg = {r[7], r == 8'h00, 1'b0, acc[3:0] < m[3:0], 1'b0, cnt != 16'h0000, 1'b1, flg[FL_C]};
      end
      mptr = i == 1 ? mptr - 16'h0001 : mptr + 16'h0001;
      exec({OP_EXT, i == 0 ? EXT_COPY_ADV : i == 1 ? EXT_COPY_RET : EXT_CMP_ADV, 16'h0000}, 16,
           bp, bp);
    end
    {b0, b1} = {OP_BASE0, 8'h00};
    start_i = 1'b1;
    tick();
    start_i = 1'b0;
    chk(illegal_o === 1'b1 && busy_o === 1'b0, "unsupported start not flagged");
    tick();
    chk(illegal_o === 1'b0 && busy_o === 1'b0 && done_o === 1'b0, "unsupported flag not a pulse");
    tick();
    conclude();
  end
endmodule
